// >>> design/parameter_access_guard.sv
// Purpose: decides parameter reads, writes and clears; masks rotation commands
// Assumes: apb master as usual; mode, run and command inputs synchronous to pclk
// Notes: one request at a time via REQ_CMD; decision lands in RESULT
`timescale 1ns/1ps
`default_nettype none

module parameter_access_guard
	import guard_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic motor_running,
	input wire logic [1:0] op_mode,
	input wire logic unit_attached,
	input wire logic panel_fwd_key,
	input wire logic panel_rev_key,
	input wire logic forward_start_input,
	input wire logic reverse_start_input,
	input wire logic comm_fwd_cmd,
	input wire logic comm_rev_cmd,
	output logic run_forward,
	output logic run_reverse
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// base level 0 (no lock) or 1..6; 101..106 fold onto 1..6
	function automatic logic [2:0] lock_base(input value_t lvl);
		if (lvl >= LEVEL_COUNT_MIN && lvl <= LEVEL_COUNT_MAX)
			lock_base = 3'(lvl - LEVEL_OFFSET);
		else if (lvl != NONE_VALUE && lvl <= LEVEL_LOW_MAX)
			lock_base = 3'(lvl);
		else
			lock_base = 3'h0;
	endfunction

	function automatic logic is_simple(input param_t p, input logic unit);
		is_simple = (p <= SIMPLE_LAST) || (p == 10'h04f) || (p == P_VISIBILITY); // 79 and 160
		if (unit && (p == 10'h00f || p == 10'h010 || p == P_CONTRAST))
			is_simple = 1'b1;
	endfunction

	function automatic logic range_ok(input param_t p, input value_t d);
		case (p)
			P_WRITE_PROTECT: range_ok = d <= value_t'(WP_ANY);
			P_ROTATION: range_ok = d <= value_t'(ROT_NO_FWD);
			P_VISIBILITY: range_ok = (d == VIS_ALL) || (d == NONE_VALUE);
			P_LOCK_LEVEL: range_ok = (d == NONE_VALUE) || (lock_base(d) != 3'h0);
			P_SOURCE: range_ok = d <= NONE_VALUE;
			default: range_ok = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// stored state

	logic [1:0] write_protect_select;
	logic [1:0] rotation_inhibit_select;
	value_t visibility_select;
	value_t lock_level;
	value_t panel_command_source_select;
	value_t lock_key;
	logic [2:0] err_count;
	lock_state_t lock_state;
	param_t req_param;
	value_t req_data;
	result_t result;

	logic apb_done;
	logic cmd_fire;
	req_t req;
	logic [2:0] lvl;
	logic locked;
	logic lockout;
	value_t key_readback;
	logic pw_read_block;
	logic pw_write_block;
	logic vis_hidden;
	logic wp_ok;
	logic needs_vis0;
	result_t next_result;
	logic wr_setting;
	logic do_register;
	logic do_unlock;
	logic do_err;
	logic do_all_clear;

	assign apb_done = psel && penable && pready;
	assign cmd_fire = apb_done && pwrite && (paddr == ADDR_REQ_CMD);
	assign req = '{param: req_param, data: req_data,
		op: pwdata[CMD_OP_LO +: 2], path: pwdata[CMD_PATH_BIT]};

	assign lvl = lock_base(lock_level);
	assign locked = (lock_state == LOCK_SET);
	assign lockout = locked && (lock_level >= LEVEL_COUNT_MIN) && (err_count == ERR_LIMIT);

	// key read value: count while counting levels are locked, else 0 or none
	always_comb
	begin
		if (lock_level == NONE_VALUE || !locked)
			key_readback = NONE_VALUE;
		else if (lock_level >= LEVEL_COUNT_MIN)
			key_readback = value_t'(err_count);
		else
			key_readback = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// password table, per path; only applies once a key is registered

	always_comb
	begin
		pw_read_block = 1'b0;
		pw_write_block = 1'b0;
		case (lvl)
			3'h1: pw_write_block = 1'b1;
			3'h2: pw_write_block = (req.path == PATH_PANEL);
			3'h3: pw_write_block = (req.path == PATH_NETWORK);
			3'h4:
			begin
				pw_read_block = 1'b1;
				pw_write_block = 1'b1;
			end
			3'h5:
			begin
				pw_read_block = (req.path == PATH_PANEL);
				pw_write_block = (req.path == PATH_PANEL);
			end
			3'h6:
			begin
				pw_read_block = (req.path == PATH_NETWORK);
				pw_write_block = (req.path == PATH_NETWORK);
			end
			default:
			begin
				pw_read_block = 1'b0;
				pw_write_block = 1'b0;
			end
		endcase
		// contrast stays reachable on an attached unit despite the lock
		if (!locked || (unit_attached && req.param == P_CONTRAST))
		begin
			pw_read_block = 1'b0;
			pw_write_block = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// visibility and write-protect gates

	// network reads see everything unless the panel source is the network
	assign vis_hidden = (visibility_select == NONE_VALUE) && !is_simple(req.param, unit_attached)
		&& ((req.path == PATH_PANEL)
		|| (panel_command_source_select == SOURCE_NETWORK_SEL));

	// write-protect and rotation writes need the full view; lock level only while it is none and unlocked
	assign needs_vis0 = (req.param == P_WRITE_PROTECT) || (req.param == P_ROTATION)
		|| (req.param == P_LOCK_LEVEL && lock_level == NONE_VALUE && !locked);

	always_comb
	begin
		wp_ok = 1'b0;
		if (req.param == P_WRITE_PROTECT || req.param == P_VISIBILITY
			|| req.param == P_LOCK_LEVEL || req.param == P_LOCK_KEY)
			wp_ok = 1'b1;
		else
			case (write_protect_select)
				WP_STOP_ONLY: wp_ok = (op_mode == MODE_PANEL) && !motor_running;
				WP_LOCKED: wp_ok = is_write_exempt(req.param);
				WP_ANY: wp_ok = !(motor_running && is_run_locked(req.param));
				default: wp_ok = 1'b0;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// decision; visibility first, then protection, then password, then range

	always_comb
	begin
		next_result = '{done: 1'b1, granted: 1'b0, reason: R_OK, rdata: '0};
		wr_setting = 1'b0;
		do_register = 1'b0;
		do_unlock = 1'b0;
		do_err = 1'b0;
		do_all_clear = 1'b0;
		case (req.op)
			OP_READ:
			begin
				if (vis_hidden)
					next_result.reason = R_VISIBLE;
				else if (pw_read_block)
					next_result.reason = R_PASSWORD;
				else
				begin
					next_result.granted = 1'b1;
					case (req.param)
						P_WRITE_PROTECT: next_result.rdata = value_t'(write_protect_select);
						P_ROTATION: next_result.rdata = value_t'(rotation_inhibit_select);
						P_VISIBILITY: next_result.rdata = visibility_select;
						P_LOCK_LEVEL: next_result.rdata = lock_level;
						P_LOCK_KEY: next_result.rdata = key_readback;
						P_SOURCE: next_result.rdata = panel_command_source_select;
						default: next_result.rdata = '0;
					endcase
				end
			end
			OP_WRITE:
			begin
				// a set lock level keeps the key enterable whatever the view
				if ((vis_hidden && !(req.param == P_LOCK_KEY && lock_level != NONE_VALUE))
					|| (needs_vis0 && visibility_select != VIS_ALL))
					next_result.reason = R_VISIBLE;
				else if (!wp_ok)
					next_result.reason = motor_running ? R_RUNNING : R_PROTECT;
				else if (req.param == P_LOCK_KEY)
				begin
					if (lock_level == NONE_VALUE)
						next_result.reason = R_PROTECT;
					else if (!locked)
					begin
						if (req.data >= KEY_MIN && req.data <= KEY_MAX)
						begin
							next_result.granted = 1'b1;
							do_register = 1'b1;
						end
						else
							next_result.reason = R_RANGE;
					end
					else if (req.data == lock_key && !lockout)
					begin
						next_result.granted = 1'b1;
						do_unlock = 1'b1;
					end
					else
					begin
						next_result.reason = R_WRONG_KEY;
						do_err = (lock_level >= LEVEL_COUNT_MIN) && (err_count != ERR_LIMIT);
					end
				end
				else if (pw_write_block || (locked && req.param == P_LOCK_LEVEL))
					next_result.reason = R_PASSWORD;
				else if (!range_ok(req.param, req.data))
					next_result.reason = R_RANGE;
				else
				begin
					next_result.granted = 1'b1;
					wr_setting = 1'b1;
				end
			end
			OP_CLEAR:
			begin
				if (write_protect_select == WP_LOCKED)
					next_result.reason = R_PROTECT;
				else if (locked)
					next_result.reason = R_PASSWORD;
				else
					next_result.granted = 1'b1;
			end
			OP_ALL_CLEAR:
			begin
				if (write_protect_select == WP_LOCKED)
					next_result.reason = R_PROTECT;
				else if (motor_running)
					next_result.reason = R_RUNNING;
				else
				begin
					next_result.granted = 1'b1;
					do_all_clear = 1'b1;
				end
			end
			default: next_result.reason = R_PROTECT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// settings; an all-clear returns every one to its initial value

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_protect_select <= WP_STOP_ONLY;
			rotation_inhibit_select <= ROT_BOTH;
			visibility_select <= VIS_ALL;
			lock_level <= NONE_VALUE;
			panel_command_source_select <= NONE_VALUE;
		end
		else if (cmd_fire && do_all_clear)
		begin
			write_protect_select <= WP_STOP_ONLY;
			rotation_inhibit_select <= ROT_BOTH;
			visibility_select <= VIS_ALL;
			lock_level <= NONE_VALUE;
			panel_command_source_select <= NONE_VALUE;
		end
		else if (cmd_fire && wr_setting)
		begin
			case (req.param)
				P_WRITE_PROTECT: write_protect_select <= req.data[1:0];
				P_ROTATION: rotation_inhibit_select <= req.data[1:0];
				P_VISIBILITY: visibility_select <= req.data;
				P_LOCK_LEVEL: lock_level <= req.data;
				P_SOURCE: panel_command_source_select <= req.data;
				default: lock_level <= lock_level;
			endcase
		end
	end

	// lock key, state and error counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_state <= LOCK_OPEN;
			lock_key <= NONE_VALUE;
			err_count <= '0;
		end
		else if (cmd_fire && (do_all_clear || do_unlock))
		begin
			lock_state <= LOCK_OPEN;
			lock_key <= NONE_VALUE;
			err_count <= '0;
		end
		else if (cmd_fire && do_register)
		begin
			lock_state <= LOCK_SET;
			lock_key <= req.data;
			err_count <= '0;
		end
		else if (cmd_fire && do_err)
			err_count <= 3'(err_count + 3'h1);
	end

	// request staging and outcome
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_param <= '0;
			req_data <= '0;
			result <= '0;
		end
		else if (apb_done && pwrite)
		begin
			if (paddr == ADDR_REQ_PARAM)
				req_param <= pwdata[9:0];
			if (paddr == ADDR_REQ_DATA)
				req_data <= pwdata[13:0];
			if (cmd_fire)
				result <= next_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: answer prepared in setup, so every access takes one wait-free beat

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			prdata <= '0;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				case (paddr)
					ADDR_REQ_PARAM: prdata <= 32'(req_param);
					ADDR_REQ_DATA: prdata <= 32'(req_data);
					ADDR_REQ_CMD: prdata <= '0; // write-only trigger
					ADDR_RESULT:
					begin
						prdata[RES_DONE_BIT] <= result.done;
						prdata[RES_GRANT_BIT] <= result.granted;
						prdata[RES_REASON_LO +: 4] <= result.reason;
						prdata[RES_DATA_LO +: 14] <= result.rdata;
						pslverr <= pwrite;
					end
					ADDR_WRITE_PROTECT:
					begin
						prdata <= 32'(write_protect_select);
						pslverr <= pwrite;
					end
					ADDR_ROTATION:
					begin
						prdata <= 32'(rotation_inhibit_select);
						pslverr <= pwrite;
					end
					ADDR_VISIBILITY:
					begin
						prdata <= 32'(visibility_select);
						pslverr <= pwrite;
					end
					ADDR_LOCK_LEVEL:
					begin
						prdata <= 32'(lock_level);
						pslverr <= pwrite;
					end
					ADDR_LOCK_KEY:
					begin
						// the key value itself is never readable
						prdata[KEY_ERR_LO +: 3] <= err_count;
						prdata[KEY_LOCK_BIT] <= locked;
						pslverr <= pwrite;
					end
					ADDR_SOURCE:
					begin
						prdata <= 32'(panel_command_source_select);
						pslverr <= pwrite;
					end
					ADDR_STATUS:
					begin
						prdata[ST_FWD_BIT] <= run_forward;
						prdata[ST_REV_BIT] <= run_reverse;
						prdata[ST_RUN_BIT] <= motor_running;
						prdata[ST_UNIT_BIT] <= unit_attached;
						prdata[ST_MODE_LO +: 2] <= op_mode;
						prdata[ST_LOCK_BIT] <= locked;
						prdata[ST_LOCKOUT_BIT] <= lockout;
						pslverr <= pwrite;
					end
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// rotation masking over every command source, one cycle of latency

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_forward <= 1'b0;
			run_reverse <= 1'b0;
		end
		else
		begin
			run_forward <= (panel_fwd_key || forward_start_input || comm_fwd_cmd)
				&& (rotation_inhibit_select != ROT_NO_FWD);
			run_reverse <= (panel_rev_key || reverse_start_input || comm_rev_cmd)
				&& (rotation_inhibit_select != ROT_NO_REV);
		end
	end

endmodule

`default_nettype wire

// >>> inc/guard_pkg.sv
// Purpose: constants, types and list lookups for the parameter access guard
// Assumes: parameter numbers and setting values fit in 10 and 14 bits
// Notes: parameter numbers are given in hex, with the decimal number alongside
package guard_pkg;

	typedef logic [9:0] param_t;
	typedef logic [13:0] value_t;

	// request carried from the bus to the decision logic
	typedef struct packed {
		param_t param;
		value_t data;
		logic [1:0] op;
		logic path;
	} req_t;

	// outcome of the last request
	typedef struct packed {
		logic done;
		logic granted;
		logic [3:0] reason;
		value_t rdata;
	} result_t;

	typedef enum logic {LOCK_OPEN, LOCK_SET} lock_state_t;

	// apb map, byte addresses
	localparam logic [7:0] ADDR_REQ_PARAM = 8'h00;
	localparam logic [7:0] ADDR_REQ_DATA = 8'h04;
	localparam logic [7:0] ADDR_REQ_CMD = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0c;
	localparam logic [7:0] ADDR_WRITE_PROTECT = 8'h10;
	localparam logic [7:0] ADDR_ROTATION = 8'h14;
	localparam logic [7:0] ADDR_VISIBILITY = 8'h18;
	localparam logic [7:0] ADDR_LOCK_LEVEL = 8'h1c;
	localparam logic [7:0] ADDR_LOCK_KEY = 8'h20;
	localparam logic [7:0] ADDR_SOURCE = 8'h24;
	localparam logic [7:0] ADDR_STATUS = 8'h28;

	// field positions
	localparam int CMD_OP_LO = 0;
	localparam int CMD_PATH_BIT = 2;
	localparam int RES_DONE_BIT = 0;
	localparam int RES_GRANT_BIT = 1;
	localparam int RES_REASON_LO = 4;
	localparam int RES_DATA_LO = 16;
	localparam int ST_FWD_BIT = 0;
	localparam int ST_REV_BIT = 1;
	localparam int ST_RUN_BIT = 2;
	localparam int ST_UNIT_BIT = 3;
	localparam int ST_MODE_LO = 4;
	localparam int ST_LOCK_BIT = 8;
	localparam int ST_LOCKOUT_BIT = 9;
	localparam int KEY_ERR_LO = 0;
	localparam int KEY_LOCK_BIT = 8;

	// request operations and paths
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_CLEAR = 2'h2;
	localparam logic [1:0] OP_ALL_CLEAR = 2'h3;
	localparam logic PATH_PANEL = 1'b0;
	localparam logic PATH_NETWORK = 1'b1;

	// operation modes on the mode input
	localparam logic [1:0] MODE_PANEL = 2'h0;

	// refusal reasons
	localparam logic [3:0] R_OK = 4'h0;
	localparam logic [3:0] R_PROTECT = 4'h1;
	localparam logic [3:0] R_VISIBLE = 4'h2;
	localparam logic [3:0] R_PASSWORD = 4'h3;
	localparam logic [3:0] R_RANGE = 4'h4;
	localparam logic [3:0] R_RUNNING = 4'h5;
	localparam logic [3:0] R_WRONG_KEY = 4'h6;

	// guard-owned parameter numbers
	localparam param_t P_WRITE_PROTECT = 10'h04d; // 77
	localparam param_t P_ROTATION = 10'h04e; // 78
	localparam param_t P_VISIBILITY = 10'h0a0; // 160
	localparam param_t P_LOCK_LEVEL = 10'h128; // 296
	localparam param_t P_LOCK_KEY = 10'h129; // 297
	localparam param_t P_SOURCE = 10'h227; // 551
	localparam param_t P_CONTRAST = 10'h3df; // 991
	localparam param_t SIMPLE_LAST = 10'h009; // simple set is 0..9 plus 79 and 160, and 15, 16 and 991 with a unit attached

	// setting values
	localparam logic [1:0] WP_STOP_ONLY = 2'h0;
	localparam logic [1:0] WP_LOCKED = 2'h1;
	localparam logic [1:0] WP_ANY = 2'h2;
	localparam logic [1:0] ROT_BOTH = 2'h0;
	localparam logic [1:0] ROT_NO_REV = 2'h1;
	localparam logic [1:0] ROT_NO_FWD = 2'h2;
	localparam value_t VIS_ALL = 14'h0000;
	localparam value_t NONE_VALUE = 14'h270f; // 9999
	localparam value_t KEY_MIN = 14'h03e8; // 1000
	localparam value_t KEY_MAX = 14'h270e; // 9998
	localparam value_t LEVEL_OFFSET = 14'h0064; // 100
	localparam value_t LEVEL_LOW_MAX = 14'h0006;
	localparam value_t LEVEL_COUNT_MIN = 14'h0065; // 101
	localparam value_t LEVEL_COUNT_MAX = 14'h006a; // 106
	localparam value_t SOURCE_NETWORK_SEL = 14'h0002;
	localparam logic [2:0] ERR_LIMIT = 3'h5;

	// writable even under full write protection
	function automatic logic is_write_exempt(input param_t p);
		case (p)
			10'h016, 10'h04b, 10'h04d, 10'h04f: is_write_exempt = 1'b1; // 22 75 77 79
			10'h0a0, 10'h128, 10'h129: is_write_exempt = 1'b1; // 160 296 297
			default: is_write_exempt = 1'b0;
		endcase
	endfunction

	// not writable while the motor runs, even with writes allowed in operation
	function automatic logic is_run_locked(input param_t p);
		case (p)
			10'h017, 10'h028, 10'h030, 10'h03c: is_run_locked = 1'b1; // 23 40 48 60
			10'h042, 10'h047, 10'h04f: is_run_locked = 1'b1; // 66 71 79
			10'h050, 10'h052, 10'h053, 10'h054, 10'h05a, 10'h060: is_run_locked = 1'b1; // 80 82 83 84 90 96
			10'h0b2, 10'h0b3, 10'h0b4, 10'h0b5, 10'h0b6: is_run_locked = 1'b1; // 178..182
			10'h0be, 10'h0c0, 10'h0c5, 10'h105: is_run_locked = 1'b1; // 190 192 197 261
			10'h12a, 10'h1c2, 10'h231: is_run_locked = 1'b1; // 298 450 561
			default: is_run_locked = 1'b0;
		endcase
	endfunction

endpackage

// >>> testbench/guard_monitor.sv
// Purpose: bus timing and direction-output checks on the guard top ports
// Assumes: single pclk domain, presetn low resets everything
// Notes: bound into every guard instance at the file foot
`timescale 1ns/1ps
`default_nettype none

module guard_monitor
	import guard_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic motor_running,
	input wire logic [1:0] op_mode,
	input wire logic unit_attached,
	input wire logic panel_fwd_key,
	input wire logic panel_rev_key,
	input wire logic forward_start_input,
	input wire logic reverse_start_input,
	input wire logic comm_fwd_cmd,
	input wire logic comm_rev_cmd,
	input wire logic run_forward,
	input wire logic run_reverse
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////
	// bus answer: one access cycle, nothing left on the data lines between
	ready_prompt_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	idle_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("data or error outside access");
	unmapped_err_a: assert property (psel && !penable && paddr > ADDR_STATUS |=> pslverr)
		else $error("unmapped access not refused");
	ro_write_a: assert property (psel && !penable && pwrite && paddr == ADDR_STATUS |=> pslverr)
		else $error("status write not refused");
	cmd_zero_a: assert property (psel && !penable && !pwrite && paddr == ADDR_REQ_CMD
		|=> prdata == 32'h0000_0000)
		else $error("command register read not zero");

	////////////////////////////////////////
	// a run output needs one of its direction sources a cycle earlier
	fwd_cause_a: assert property (run_forward
		|-> $past(panel_fwd_key | forward_start_input | comm_fwd_cmd))
		else $error("forward without a source");
	rev_cause_a: assert property (run_reverse
		|-> $past(panel_rev_key | reverse_start_input | comm_rev_cmd))
		else $error("reverse without a source");
endmodule

bind parameter_access_guard guard_monitor u_guard_monitor (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_running(motor_running),
	.op_mode(op_mode), .unit_attached(unit_attached), .panel_fwd_key(panel_fwd_key),
	.panel_rev_key(panel_rev_key), .forward_start_input(forward_start_input),
	.reverse_start_input(reverse_start_input), .comm_fwd_cmd(comm_fwd_cmd),
	.comm_rev_cmd(comm_rev_cmd), .run_forward(run_forward), .run_reverse(run_reverse));

`default_nettype wire

// >>> testbench/guard_host.sv
// Purpose: apb master standing in for the panel and network host
// Assumes: one transfer at a time
// Notes: waits on pready for as long as it takes; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none

module guard_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	////////////////////////////////////////
	// an idle edge first, so psel is never assigned twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~d; // released data no longer shows the old word
	endtask
endmodule

`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the parameter access guard
// Assumes: host model speaks apb; direction inputs drawn at random
// Notes: expected outcomes come from the bench tables and functions
`timescale 1ns/1ps
`default_nettype none

module testbench
	import guard_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr, msk;
	logic [31:0] pwdata, prdata, res, rv;
	logic motor_running, unit_attached, run_forward, run_reverse;
	logic [1:0] op_mode;
	logic [5:0] dir;
	int fails, total_checks;
	integer seed;
	param_t ex[4] = '{10'h016, 10'h04b, 10'h04f, 10'h0a0};
	param_t rl[3] = '{10'h017, 10'h0b4, 10'h231};
	localparam logic [7:0] GO = {R_OK, 4'h3};

	parameter_access_guard u_parameter_access_guard (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_running(motor_running),
		.op_mode(op_mode), .unit_attached(unit_attached), .panel_fwd_key(dir[0]),
		.panel_rev_key(dir[1]), .forward_start_input(dir[2]), .reverse_start_input(dir[3]),
		.comm_fwd_cmd(dir[4]), .comm_rev_cmd(dir[5]), .run_forward(run_forward),
		.run_reverse(run_reverse));
	guard_host u_guard_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 100 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [7:0] ng(input logic [3:0] r);
		ng = {r, 4'h1};
	endfunction

	// run outputs a direction set should give under an inhibit setting
	function automatic logic [1:0] dexp(input logic [1:0] rot, input logic [5:0] d);
		dexp = {(d[1] | d[3] | d[5]) & (rot != ROT_NO_REV), (d[0] | d[2] | d[4]) & (rot != ROT_NO_FWD)};
	endfunction

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] x);
		u_guard_host.xfer(1'h0, a, 32'h0000_0000, rv, e);
		chk(rv, x);
	endtask

	// one request, then done, grant and reason under the current mask
	task automatic req(input param_t p, input value_t d, input logic [1:0] op, input logic pa,
		input logic [7:0] x);
		u_guard_host.xfer(1'h1, ADDR_REQ_PARAM, {22'h0, p}, rv, e);
		u_guard_host.xfer(1'h1, ADDR_REQ_DATA, {18'h0, d}, rv, e);
		u_guard_host.xfer(1'h1, ADDR_REQ_CMD, {29'h0, pa, op}, rv, e);
		u_guard_host.xfer(1'h0, ADDR_RESULT, 32'h0000_0000, res, e);
		chk({24'h0, res[7:0] & msk}, {24'h0, x & msk});
	endtask

	task automatic wr(input param_t p, input value_t d, input logic [7:0] x);
		req(p, d, OP_WRITE, PATH_PANEL, x);
	endtask

	task automatic dir_run(input logic [1:0] rot);
		repeat (6)
		begin
			@(posedge pclk);
			dir <= 6'($random(seed));
			@(posedge pclk);
			#1;
			chk({30'h0, run_reverse, run_forward}, {30'h0, dexp(rot, dir)});
		end
	endtask

	////////////////////////////////////////
	// watchdog: far beyond the under one thousand cycles the sequence needs
	initial
	begin
		#200_000;
		fails++;
		results();
	end

	initial
	begin
		seed = 32'hd525;
		fails = 0;
		total_checks = 0;
		msk = 8'hff;
		presetn = 1'h0;
		motor_running = 1'h0;
		op_mode = MODE_PANEL;
		unit_attached = 1'h0;
		dir = 6'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		reg_rd(ADDR_WRITE_PROTECT, 32'h0000_0000);
		reg_rd(ADDR_ROTATION, 32'h0000_0000);
		reg_rd(ADDR_LOCK_LEVEL, 32'h0000_270f);
		reg_rd(ADDR_LOCK_KEY, 32'h0000_0000);
		u_guard_host.xfer(1'h0, 8'h2c, 32'h0000_0000, rv, e);
		chk({31'h0, e}, 32'h0000_0001);
		u_guard_host.xfer(1'h1, ADDR_STATUS, 32'h0000_ffff, rv, e);
		chk({31'h0, e}, 32'h0000_0001);
		// stop-only writes: the reason code is left open here
		msk = 8'h03;
		op_mode <= 2'h1;
		wr(10'h001, 14'h0005, ng(R_PROTECT));
		op_mode <= MODE_PANEL;
		motor_running <= 1'h1;
		wr(10'h001, 14'h0005, ng(R_PROTECT));
		motor_running <= 1'h0;
		msk = 8'hff;
		wr(10'h001, 14'h0005, GO);
		wr(P_WRITE_PROTECT, 14'h0003, ng(R_RANGE));
		reg_rd(ADDR_WRITE_PROTECT, 32'h0000_0000);
		for (int k = 0; k < 3; k++)
		begin
			wr(P_ROTATION, 14'(k), GO);
			dir_run(2'(k));
		end
		wr(P_WRITE_PROTECT, 14'(WP_LOCKED), GO);
		wr(10'h001, 14'h0005, ng(R_PROTECT));
		req(10'h001, 14'h0000, OP_READ, PATH_PANEL, GO);
		req(10'h001, 14'h0000, OP_CLEAR, PATH_PANEL, ng(R_PROTECT));
		req(10'h001, 14'h0000, OP_ALL_CLEAR, PATH_PANEL, ng(R_PROTECT));
		foreach (ex[i])
			wr(ex[i], 14'h0000, GO);
		wr(P_WRITE_PROTECT, 14'(WP_ANY), GO);
		motor_running <= 1'h1;
		op_mode <= 2'h1;
		wr(10'h001, 14'h0007, GO);
		foreach (rl[i])
			wr(rl[i], 14'h0000, ng(R_RUNNING));
		wr(P_WRITE_PROTECT, 14'(WP_STOP_ONLY), GO);
		wr(P_LOCK_LEVEL, NONE_VALUE, GO);
		wr(P_VISIBILITY, NONE_VALUE, GO);
		req(P_ROTATION, 14'h0001, OP_WRITE, PATH_NETWORK, ng(R_VISIBLE));
		req(10'h064, 14'h0000, OP_READ, PATH_PANEL, ng(R_VISIBLE));
		req(10'h005, 14'h0000, OP_READ, PATH_PANEL, GO);
		req(10'h064, 14'h0000, OP_READ, PATH_NETWORK, GO);
		unit_attached <= 1'h1;
		req(10'h00f, 14'h0000, OP_READ, PATH_PANEL, GO);
		unit_attached <= 1'h0;
		req(10'h00f, 14'h0000, OP_READ, PATH_PANEL, ng(R_VISIBLE));
		wr(P_VISIBILITY, VIS_ALL, GO);
		motor_running <= 1'h0;
		op_mode <= MODE_PANEL;
		wr(P_LOCK_LEVEL, 14'h0007, ng(R_RANGE));
		wr(P_LOCK_LEVEL, LEVEL_COUNT_MIN, GO);
		wr(P_LOCK_KEY, 14'h04d2, GO);
		reg_rd(ADDR_LOCK_KEY, 32'h0000_0100);
		wr(10'h001, 14'h0005, ng(R_PASSWORD));
		req(10'h001, 14'h0000, OP_READ, PATH_NETWORK, GO);
		repeat (5)
			wr(P_LOCK_KEY, 14'h0457, ng(R_WRONG_KEY));
		req(P_LOCK_KEY, 14'h0000, OP_READ, PATH_PANEL, GO);
		chk({18'h0, res[29:16]}, 32'h0000_0005);
		reg_rd(ADDR_STATUS, {22'h0, 2'h3, 6'h00, dexp(ROT_NO_FWD, dir)});
		msk = 8'h03;
		wr(P_LOCK_KEY, 14'h04d2, ng(R_WRONG_KEY));
		motor_running <= 1'h1;
		req(10'h000, 14'h0000, OP_ALL_CLEAR, PATH_PANEL, ng(R_RUNNING));
		motor_running <= 1'h0;
		msk = 8'hff;
		req(10'h000, 14'h0000, OP_ALL_CLEAR, PATH_PANEL, GO);
		reg_rd(ADDR_LOCK_LEVEL, 32'h0000_270f);
		reg_rd(ADDR_LOCK_KEY, 32'h0000_0000);
		wr(P_LOCK_LEVEL, 14'h0003, GO);
		wr(P_LOCK_KEY, 14'h07d0, GO);
		req(10'h001, 14'h0005, OP_WRITE, PATH_NETWORK, ng(R_PASSWORD));
		wr(10'h001, 14'h0005, GO);
		wr(P_VISIBILITY, NONE_VALUE, GO);
		req(10'h064, 14'h0000, OP_READ, PATH_PANEL, ng(R_VISIBLE));
		wr(P_LOCK_KEY, 14'h07d0, GO);
		req(10'h001, 14'h0005, OP_WRITE, PATH_NETWORK, GO);
		results();
	end
endmodule

`default_nettype wire
